// ### core/serial_mem_pkg.sv
// Purpose: Shared constants for the two-wire serial memory front end
// Assumes: Byte-wide array, 16-bit byte address
// Notes: Type identifier value is arbitrary
package serial_mem_pkg;
  // Arbitrary identifier value, not tied to any part
  localparam logic [3:0] TYPE_ID = 4'h5;
  localparam int TYPE_ID_MSB = 7;
  localparam int TYPE_ID_LSB = 4;
  localparam int CSEL_MSB = 3;
  localparam int CSEL_LSB = 1;
  localparam int DIR_BIT = 0;
  localparam logic DIR_READ = 1'b1;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int DEPTH_LARGE = 65536;
  localparam int DEPTH_SMALL = 32768;
  localparam logic [2:0] BIT_CNT_RESET = 3'h7;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SELECT,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WRITE,
    ST_READ,
    ST_READ_ACK
  } fe_state_t;
endpackage

// ### core/mem_port_if.sv
// Purpose: Carrier between the front end and its byte array
// Assumes: One access per clock
// Notes: Read data registered in the array
`timescale 1ns/1ps
interface mem_port_if;
  import serial_mem_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport front (output wr_en, output addr, output wdata, input rdata);
  modport array (input wr_en, input addr, input wdata, output rdata);
endinterface

// ### core/byte_array.sv
// Purpose: Byte-wide storage array
// Assumes: Synchronous write and registered read
// Notes: Small variant wraps address bits above its depth
`timescale 1ns/1ps
module byte_array
  import serial_mem_pkg::*;
#(
  parameter bit LARGE = 1'b1
)
(
  // Clock
  input wire logic clk_in,
  // Access port
  mem_port_if.array port
);
  localparam int DEPTH = LARGE ? DEPTH_LARGE : DEPTH_SMALL;
  localparam int IDX_W = $clog2(DEPTH);

  logic [DATA_W-1:0] mem [DEPTH];
  logic [IDX_W-1:0] idx;

  assign idx = port.addr[IDX_W-1:0];

  always_ff @(posedge clk_in)
  begin
    if (port.wr_en)
    begin
      mem[idx] <= port.wdata; // [R01]
    end
  end

  always_ff @(posedge clk_in)
  begin
    port.rdata <= mem[idx];
  end
endmodule // byte_array

// ### core/serial_mem_front.sv
// Purpose: Two-wire slave front end of a byte-wide serial memory
// Assumes: Serial clock well below clk_in/4; both lines synchronised here
// Notes: Write cycle timing and packet handling live elsewhere
// Summary of operation
// [R01] Byte-wide array of 65536 or 32768 locations, reached only serially.
// [R02] Slave only; transfers open with start, select byte, acknowledge slot.
// [R03] Device acknowledges in ninth bit period after each received byte.
// [R04] Master acknowledges each read byte in the ninth bit period.
// [R05] Master ends writes after ack, reads after withheld ack, with stop.
// [R06] Serial clock times every bit; no other serial timing source.
// [R07] Data line driven open-drain only: pull low or release.
// [R08] Select byte upper nibble must equal fixed type identifier.
// [R09] Three chip-select pins give expected select bits three to one.
// [R10] Select byte: type id top, chip-select bits 3..1, direction bit 0.
// [R11] Select byte arrives most significant bit first.
// [R12] Floating chip-select pins read as zero.
// [R13] Write-protect high prevents any array modification; code samples it only at start and at the two address bytes.
// [R14] Unconnected write-protect reads low, writes allowed.
// [R15] Under protection select and address acked, data bytes not acked.
// [R16] Sixteen-bit byte address in two bytes, high then low.
// [R17] Bus ignored until supply passes power-on threshold.
// [R18] After threshold, block starts in standby, deselected.
// [R19] Below threshold on power-down, block stops responding.
// [R20] Direction bit one means read, zero means write.
// [R21] High address byte is sent before low address byte.
// [R22] Data sampled on each rising serial clock edge when receiving.
// [R23] Mismatched select: no acknowledge, back to standby until start.
// [R24] Active-low power-good input holds reset and releases data line.
`timescale 1ns/1ps
module serial_mem_front
  import serial_mem_pkg::*;
#(
  parameter bit LARGE = 1'b1
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic power_good_n_in,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Straps, pulled low outside when floating
  input wire logic chip_select_pin_0,
  input wire logic chip_select_pin_1,
  input wire logic chip_select_pin_2,
  input wire logic write_protect_in,
  // Status
  output logic selected_out,
  output logic [ADDR_W-1:0] addr_out
);
  mem_port_if mport();

  byte_array #(.LARGE(LARGE)) u_array
  (
    .clk_in(clk_in),
    .port(mport.array)
  );

  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] pg_sync_reg;
  logic [3:0] strap_sync0_reg;
  logic [3:0] strap_sync1_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic rst;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Pins enter through two flops each; first flop feeds only the second
  always_ff @(posedge clk_in)
  begin
    scl_sync_reg <= {scl_sync_reg[0], scl_in};
    sda_sync_reg <= {sda_sync_reg[0], sda_in};
    pg_sync_reg <= {pg_sync_reg[0], power_good_n_in};
    strap_sync0_reg <= {write_protect_in, chip_select_pin_2, chip_select_pin_1,
                        chip_select_pin_0};
    strap_sync1_reg <= strap_sync0_reg;
  end

  // Power-good input high (power not good) holds everything in reset
  assign rst = sys_rst_in | pg_sync_reg[1]; // [R17] [R19] [R24]

  always_ff @(posedge clk_in)
  begin
    scl_d_reg <= scl_sync_reg[1];
    sda_d_reg <= sda_sync_reg[1];
  end

  assign scl_rise = scl_sync_reg[1] & ~scl_d_reg; // [R06]
  assign scl_fall = ~scl_sync_reg[1] & scl_d_reg;
  assign start_det = scl_sync_reg[1] & scl_d_reg & sda_d_reg & ~sda_sync_reg[1]; // [R02]
  assign stop_det = scl_sync_reg[1] & scl_d_reg & ~sda_d_reg & sda_sync_reg[1];

  function automatic logic select_match(input logic [7:0] sel, input logic [2:0] pins);
    select_match = (sel[TYPE_ID_MSB:TYPE_ID_LSB] == TYPE_ID) && // [R08] [R10]
                   (sel[CSEL_MSB:CSEL_LSB] == pins); // [R09] [R12]
  endfunction

  fe_state_t state_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_phase_reg;
  logic ack_drive_reg;
  logic ack_want_reg;
  logic protect_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] tx_reg;
  logic wr_pulse_reg;
  logic master_ack_reg;
  logic [7:0] rx_byte;
  logic protect_now;

  assign rx_byte = {shift_reg[6:0], sda_sync_reg[1]};
  assign protect_now = strap_sync1_reg[3]; // [R14]

  // Bit counter and shifter run on serial clock edges only
  always_ff @(posedge clk_in)
  begin
    if (rst || start_det)
    begin
      bit_cnt_reg <= BIT_CNT_RESET;
      ack_phase_reg <= 1'b0;
    end
    else if (scl_rise && !ack_phase_reg)
    begin
      shift_reg <= rx_byte; // [R11] [R22]
      bit_cnt_reg <= bit_cnt_reg - 3'h0_001;
      if (bit_cnt_reg == 3'h0_000)
      begin
        ack_phase_reg <= 1'b1;
      end
    end
    else if (scl_rise && ack_phase_reg)
    begin
      bit_cnt_reg <= BIT_CNT_RESET;
      ack_phase_reg <= 1'b0;
    end
  end

  // Protocol state
  always_ff @(posedge clk_in)
  begin
    wr_pulse_reg <= 1'b0;
    if (rst)
    begin
      state_reg <= ST_IDLE; // [R18]
      addr_reg <= ADDR_RESET;
      protect_reg <= 1'b0;
      master_ack_reg <= 1'b0;
    end
    else if (start_det)
    begin
      state_reg <= ST_SELECT; // [R02]
      protect_reg <= protect_now;
    end
    else if (stop_det)
    begin
      state_reg <= ST_IDLE; // [R05]
    end
    else if (scl_rise && !ack_phase_reg && bit_cnt_reg == 3'h0_000)
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
        end
        ST_SELECT:
        begin
          if (!select_match(rx_byte, strap_sync1_reg[2:0]))
          begin
            state_reg <= ST_IDLE; // [R23]
          end
          else if (rx_byte[DIR_BIT] == DIR_READ)
          begin
            state_reg <= ST_READ; // [R20]
          end
          else
          begin
            state_reg <= ST_ADDR_HI;
          end
        end
        ST_ADDR_HI:
        begin
          addr_reg[15:8] <= rx_byte; // [R16] [R21]
          protect_reg <= protect_reg | protect_now;
          state_reg <= ST_ADDR_LO;
        end
        ST_ADDR_LO:
        begin
          addr_reg[7:0] <= rx_byte; // [R16]
          protect_reg <= protect_reg | protect_now;
          state_reg <= ST_WRITE;
        end
        ST_WRITE:
        begin
          wr_pulse_reg <= ~protect_reg; // [R13]
        end
        ST_READ:
        begin
          state_reg <= ST_READ_ACK;
        end
        ST_READ_ACK:
        begin
          state_reg <= ST_READ_ACK;
        end
      endcase
    end
    else if (scl_rise && ack_phase_reg)
    begin
      if (state_reg == ST_READ_ACK)
      begin
        master_ack_reg <= ~sda_sync_reg[1]; // [R04]
        addr_reg <= addr_reg + 16'h0_001;
        state_reg <= sda_sync_reg[1] ? ST_IDLE : ST_READ; // [R05]
      end
    end
    if (!rst && wr_pulse_reg)
    begin
      addr_reg <= addr_reg + 16'h0_001;
    end
  end

  assign mport.wr_en = wr_pulse_reg; // [R13]
  assign mport.addr = addr_reg;
  assign mport.wdata = shift_reg;

  // First bit comes straight from the array, the rest shift out on falls
  always_ff @(posedge clk_in)
  begin
    if (rst)
    begin
      tx_reg <= 8'h00;
    end
    else if (scl_fall && !ack_phase_reg && state_reg == ST_READ)
    begin
      if (bit_cnt_reg == BIT_CNT_RESET)
      begin
        tx_reg <= {mport.rdata[6:0], 1'b0};
      end
      else
      begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // Decided at the eighth rise, while the state still names the byte just taken
  always_ff @(posedge clk_in)
  begin
    if (rst || start_det || stop_det)
    begin
      ack_want_reg <= 1'b0;
    end
    else if (scl_rise && !ack_phase_reg && bit_cnt_reg == 3'h0)
    begin
      unique case (state_reg)
        ST_SELECT: ack_want_reg <= select_match(rx_byte, strap_sync1_reg[2:0]); // [R03] [R23]
        ST_ADDR_HI, ST_ADDR_LO: ack_want_reg <= 1'b1; // [R03] [R15]
        ST_WRITE: ack_want_reg <= ~protect_reg; // [R15]
        default: ack_want_reg <= 1'b0;
      endcase
    end
  end

  // Drive changes only on falling serial clock, so data is stable while high
  always_ff @(posedge clk_in)
  begin
    if (rst || start_det || stop_det)
    begin
      ack_drive_reg <= 1'b0; // [R24]
    end
    else if (scl_fall)
    begin
      if (ack_phase_reg)
      begin
        ack_drive_reg <= ack_want_reg; // [R03] [R15]
      end
      else if (state_reg == ST_READ && bit_cnt_reg == BIT_CNT_RESET)
      begin
        ack_drive_reg <= ~mport.rdata[7];
      end
      else if (state_reg == ST_READ)
      begin
        ack_drive_reg <= ~tx_reg[7];
      end
      else
      begin
        ack_drive_reg <= 1'b0;
      end
    end
  end

  // Open drain: output always low, enable pulls the line
  assign sda_out = 1'b0; // [R07]
  assign sda_oe_out = ack_drive_reg; // [R07]
  assign selected_out = (state_reg != ST_IDLE) && (state_reg != ST_SELECT);
  assign addr_out = addr_reg;

  a_ack_in_ninth: assert property (@(posedge clk_in) disable iff (rst)
    (scl_rise && !ack_phase_reg && bit_cnt_reg == 3'h0_000 && state_reg == ST_ADDR_HI)
    |=> ##[1:200] (sda_oe_out || start_det || stop_det))
    else $error("address byte not acknowledged"); // [R03]
  a_protect_no_write: assert property (@(posedge clk_in) disable iff (rst)
    protect_reg |-> !mport.wr_en)
    else $error("array written while protected"); // [R13]
  a_pg_release_line: assert property (@(posedge clk_in)
    pg_sync_reg[1] |=> !sda_oe_out && state_reg == ST_IDLE)
    else $error("line held during power-down"); // [R24]
  a_mismatch_idle: assert property (@(posedge clk_in) disable iff (rst)
    (state_reg == ST_SELECT && scl_rise && !ack_phase_reg && bit_cnt_reg == 3'h0_000
     && !select_match(rx_byte, strap_sync1_reg[2:0]) && !start_det && !stop_det)
    |=> state_reg == ST_IDLE)
    else $error("mismatched select kept"); // [R23]
  a_open_drain: assert property (@(posedge clk_in) sda_out == 1'b0)
    else $error("data line driven high"); // [R07]
  a_stop_standby: assert property (@(posedge clk_in) disable iff (rst)
    (stop_det && !start_det) |=> state_reg == ST_IDLE)
    else $error("stop did not return standby"); // [R05]
  a_start_select: assert property (@(posedge clk_in) disable iff (rst)
    start_det |=> state_reg == ST_SELECT && bit_cnt_reg == BIT_CNT_RESET)
    else $error("start not followed by select"); // [R02]
  a_idle_quiet: assert property (@(posedge clk_in) disable iff (rst)
    (state_reg == ST_IDLE && $past(state_reg) == ST_IDLE && !ack_phase_reg) |-> !sda_oe_out)
    else $error("line pulled while deselected"); // [R18]
  a_edge_only: assert property (@(posedge clk_in) disable iff (rst)
    (!scl_rise && !start_det) |=> $stable(bit_cnt_reg))
    else $error("bit counter moved without clock"); // [R06]
endmodule // serial_mem_front

// ### testbench/i2c_master_model.sv
// Purpose: Two-wire bus master model driving clock and data
// Assumes: Data line pulled up outside; clock push-pull
// Notes: Clock stands high between frames, data only pulled low or released
`timescale 1ns/1ps
module i2c_master_model
(
  // Clock
  input wire logic clk_in,
  // Bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial
  begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Quarter of a 160 ns bit period
  task automatic qtr();
    repeat (10) @(posedge clk_in);
  endtask
  // Also serves as repeated start from clock low
  task automatic bus_start();
    sda_low_out <= 1'b0;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_low_out <= 1'b1;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask
  task automatic bus_stop();
    sda_low_out <= 1'b1;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_low_out <= 1'b0;
    qtr();
  endtask
  // Data changes only with clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_low_out <= ~b;
    qtr();
    scl_out <= 1'b1;
    qtr();
    s = sda_in;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~give_ack, s);
  endtask
endmodule // i2c_master_model

// ### testbench/i2c_eeprom_slave_front_end_tb_top.sv
// Purpose: Self-checking bench for the serial memory front end
// Assumes: Bus master model on the far side, 160 ns bit period
// Notes: Straps always driven, never left floating
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin checks_done++; if ((g) !== (e)) \
  begin failures++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module i2c_eeprom_slave_front_end_tb_top import serial_mem_pkg::*;;
  logic clk_in;
  logic sys_rst_in;
  logic power_good_n_in;
  logic [2:0] cs_pins;
  logic write_protect;
  logic scl;
  logic m_low;
  logic dev_sda;
  logic dev_oe;
  logic selected;
  logic [ADDR_W-1:0] addr;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  wire sda_wire = ~(m_low | (dev_oe & ~dev_sda));
  i2c_master_model i_i2c_master_model (.clk_in(clk_in), .sda_in(sda_wire),
    .scl_out(scl), .sda_low_out(m_low));
  serial_mem_front i_serial_mem_front (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .power_good_n_in(power_good_n_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(dev_sda), .sda_oe_out(dev_oe), .chip_select_pin_0(cs_pins[0]),
    .chip_select_pin_1(cs_pins[1]), .chip_select_pin_2(cs_pins[2]),
    .write_protect_in(write_protect), .selected_out(selected), .addr_out(addr));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic conclude();
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Whole run is about 18800 cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      conclude();
    end
  end
  task automatic t_write(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    logic ack;
    i_i2c_master_model.bus_start();
    i_i2c_master_model.send_byte({TYPE_ID, cs_pins, 1'b0}, ack);
    `CHK("select ack", 1'b1, ack)
    `CHK("selected", 1'b1, selected)
    i_i2c_master_model.send_byte(a[15:8], ack);
    `CHK("addr hi ack", 1'b1, ack)
    i_i2c_master_model.send_byte(a[7:0], ack);
    `CHK("addr lo ack", 1'b1, ack)
    `CHK("address", a, addr)
    i_i2c_master_model.send_byte(d0, ack);
    `CHK("data ack", ~write_protect, ack)
    i_i2c_master_model.send_byte(d1, ack);
    `CHK("data ack", ~write_protect, ack)
    i_i2c_master_model.bus_stop();
    repeat (10) @(posedge clk_in);
    `CHK("idle after stop", 1'b0, selected)
  endtask
  task automatic t_read(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
    logic ack;
    logic [7:0] d;
    i_i2c_master_model.bus_start();
    i_i2c_master_model.send_byte({TYPE_ID, cs_pins, 1'b0}, ack);
    i_i2c_master_model.send_byte(a[15:8], ack);
    i_i2c_master_model.send_byte(a[7:0], ack);
    i_i2c_master_model.bus_start();
    i_i2c_master_model.send_byte({TYPE_ID, cs_pins, DIR_READ}, ack);
    `CHK("read select ack", 1'b1, ack)
    i_i2c_master_model.recv_byte(1'b1, d);
    `CHK("read byte 0", e0, d)
    i_i2c_master_model.recv_byte(1'b0, d);
    `CHK("read byte 1", e1, d)
    i_i2c_master_model.bus_stop();
  endtask
  // Flip the type top bit, then each chip-select bit
  task automatic t_reject();
    logic ack;
    logic [7:0] m;
    for (int i = 0; i < 4; i++)
    begin
      m = (i == 0) ? 8'h80 : (8'h10 >> i);
      i_i2c_master_model.bus_start();
      i_i2c_master_model.send_byte({TYPE_ID, cs_pins, 1'b0} ^ m, ack);
      `CHK("mismatch ack", 1'b0, ack)
      `CHK("mismatch selected", 1'b0, selected)
      i_i2c_master_model.bus_stop();
    end
  endtask
  task automatic t_power();
    logic ack;
    power_good_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    i_i2c_master_model.bus_start();
    i_i2c_master_model.send_byte({TYPE_ID, cs_pins, 1'b0}, ack);
    `CHK("power down ack", 1'b0, ack)
    i_i2c_master_model.bus_stop();
    power_good_n_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    `CHK("power up selected", 1'b0, selected)
  endtask
  initial
  begin
    sys_rst_in = 1'b1;
    power_good_n_in = 1'b0;
    cs_pins = 3'h0;
    write_protect = 1'b0;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    `CHK("reset address", 16'h0000, addr)
    `CHK("reset drive", 1'b0, dev_oe)
    t_write(16'h1234, 8'hA5, 8'h3C);
    t_read(16'h1234, 8'hA5, 8'h3C);
    write_protect <= 1'b1;
    t_write(16'h1234, 8'h00, 8'hFF);
    write_protect <= 1'b0;
    t_read(16'h1234, 8'hA5, 8'h3C);
    cs_pins <= 3'h5;
    t_reject();
    t_write(16'h7FFF, 8'h5A, 8'hC3);
    t_read(16'h7FFF, 8'h5A, 8'hC3);
    t_power();
    t_write(16'h0000, 8'h11, 8'h22);
    t_read(16'h0000, 8'h11, 8'h22);
    conclude();
  end
endmodule // i2c_eeprom_slave_front_end_tb_top
